// [tw_map.svh]
// register offsets, field positions and reset values of the capture/compare timer
`ifndef TW_MAP_SVH
`define TW_MAP_SVH
`define TW_OFS_MODE      6'h00
`define TW_OFS_CTRL      6'h04
`define TW_OFS_IEN       6'h08
`define TW_OFS_STAT      6'h0c
`define TW_OFS_IOAB      6'h10
`define TW_OFS_IOCD      6'h14
`define TW_OFS_CNT       6'h18
`define TW_OFS_GRA       6'h1c
`define TW_OFS_GRB       6'h20
`define TW_OFS_GRC       6'h24
`define TW_OFS_GRD       6'h28
`define TW_MODE_RUN      7
`define TW_MODE_BUFB     5
`define TW_MODE_BUFA     4
`define TW_MODE_PWM_SEL_D     2
`define TW_MODE_PWM_SEL_C     1
`define TW_MODE_PWM_SEL_B     0
`define TW_MODE_RSVD     8'h48
`define TW_CTRL_CLR      7
`define TW_CTRL_CKS_HI   6
`define TW_CTRL_CKS_LO   4
`define TW_IEN_OVF       7
`define TW_IEN_RSVD      8'h70
`define TW_STAT_OVF      7
`define TW_STAT_RSVD     8'h70
`define TW_IO_RSVD       8'h88
`define TW_IO_HI_FS      6
`define TW_IO_LO_FS      2
`define TW_RST_BYTE      8'h00
`define TW_RST_CNT       16'h0000
`define TW_RST_GR        16'hffff
`define TW_CNT_MAX       16'hffff
`endif

// [tw_pkg.sv]
// shared types of the capture/compare timer
package tw_pkg;
	typedef logic [15:0] tw_word_t;
	typedef enum logic [1:0] {
		TW_ACT_NONE,
		TW_ACT_LOW,
		TW_ACT_HIGH,
		TW_ACT_TOGGLE
	} tw_action_t;
endpackage : tw_pkg

// [tw_timer.sv]
// capture/compare timer with four general registers behind an avalon-mm slave
`timescale 1ns/100ps
`default_nettype none
`include "tw_map.svh"
// Notes on behaviour
// [RULE_01] counter counts only while the run bit is 1; run resets to 0
// [RULE_02] buffer select b makes register d the buffer of register b
// [RULE_03] buffer select a makes register c the buffer of register a
// [RULE_04] pwm selects switch pins d, c, b to pwm output
// [RULE_05] reserved bits of mode, status and io control read as 1
// [RULE_06] clear-on-match-a clears the counter at match a, else free running
// [RULE_07] clock select: clk, clk/2, clk/4, clk/8, or external event rising edges
// [RULE_08] undivided source counts the subclock while chip is in sub modes
// [RULE_09] level bits set each pin value until its first compare match
// [RULE_10] writing a level bit changes the pin at once
// [RULE_11] overflow request is the overflow flag gated by its enable
// [RULE_12] each channel request is its flag gated by its own enable
// [RULE_13] overflow flag sets when the counter wraps from ffff to 0
// [RULE_14] a flag clears only by writing 0 after reading it as 1
// [RULE_15] output compare sets the channel flag when counter equals register
// [RULE_16] input capture copies the counter on the chosen edge and sets flag
// [RULE_17] function select 0 means compare, 1 means capture
// [RULE_18] compare action 00 none, 01 low, 10 high, 11 toggle
// [RULE_19] capture edge 00 rising, 01 falling, 1x both
// [RULE_20] channel d uses the same encodings on register d and its pin
// [RULE_21] buffered a: compare loads c into a; capture moves a to c
// [RULE_22] pwm pin takes level at match a and inverse at own match
// [RULE_23] counter resets to 0, general registers to ffff, 16-bit access only
// [RULE_24] channel c uses the same encodings on register c
// [RULE_25] a flag set in the cycle of its clear stays set
module tw_timer #(
	parameter int PRE_W = 3
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic [5:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic [3:0]  i_ch_pin,
	output logic      [3:0]  o_ch_out,
	output logic      [3:0]  o_ch_oe_n,
	input  wire logic        i_ext_event_pin,
	input  wire logic        i_subclk,
	input  wire logic        i_sub_mode,
	output logic             o_overflow_interrupt,
	output logic      [3:0]  o_event_interrupt
);
	if (PRE_W < 3) begin : g_chk
		$error("prescaler must reach clk/8");
	end

	logic             ack_r;
	logic [31:0]      rdata_r;
	logic [7:0]       mode_r;
	logic [7:0]       ctrl_r;
	logic [7:0]       ien_r;
	logic [7:0]       ioab_r;
	logic [7:0]       iocd_r;
	logic [4:0]       flag_r;
	logic [4:0]       flag_nxt;
	logic [4:0]       armed_r;
	logic [3:0]       lvl_r;
	logic [3:0]       lvl_nxt;
	tw_pkg::tw_word_t cnt_r;
	tw_pkg::tw_word_t cnt_nxt;
	tw_pkg::tw_word_t gr_r   [4];
	tw_pkg::tw_word_t gr_nxt [4];
	logic [PRE_W-1:0] pre_r;
	logic [5:0]       sy1_r;
	logic [5:0]       sy2_r;
	logic [5:0]       sy3_r;
	logic [5:0]       stb_r;
	logic [5:0]       stb_nxt;

	// bus decode: every access waits exactly one cycle
	wire       acc     = i_avs_read | i_avs_write;
	wire       done    = acc & ack_r;
	wire       wr_done = i_avs_write & ack_r;
	wire       rd_done = i_avs_read & ack_r;
	wire       be8     = i_avs_byteenable[0];
	wire       be16    = &i_avs_byteenable[1:0];
	wire [7:0] wd8     = i_avs_writedata[7:0];
	wire [15:0] wd16   = i_avs_writedata[15:0];
	wire       sel_mode = i_avs_address == `TW_OFS_MODE;
	wire       sel_ctrl = i_avs_address == `TW_OFS_CTRL;
	wire       sel_ien  = i_avs_address == `TW_OFS_IEN;
	wire       sel_stat = i_avs_address == `TW_OFS_STAT;
	wire       sel_ioab = i_avs_address == `TW_OFS_IOAB;
	wire       sel_iocd = i_avs_address == `TW_OFS_IOCD;
	wire       sel_cnt  = i_avs_address == `TW_OFS_CNT;
	wire [3:0] sel_gr;
	assign sel_gr[0] = i_avs_address == `TW_OFS_GRA;
	assign sel_gr[1] = i_avs_address == `TW_OFS_GRB;
	assign sel_gr[2] = i_avs_address == `TW_OFS_GRC;
	assign sel_gr[3] = i_avs_address == `TW_OFS_GRD;
	// byte-wide writes to 16-bit registers are dropped
	wire       wr_mode = wr_done & sel_mode & be8;
	wire       wr_ctrl = wr_done & sel_ctrl & be8;
	wire       wr_ien  = wr_done & sel_ien & be8;
	wire       wr_stat = wr_done & sel_stat & be8;
	wire       wr_ioab = wr_done & sel_ioab & be8;
	wire       wr_iocd = wr_done & sel_iocd & be8;
	wire       wr_cnt  = wr_done & sel_cnt & be16; // RULE_23
	wire [3:0] wr_gr   = {4{wr_done & be16}} & sel_gr; // RULE_23

	assign o_avs_waitrequest = acc & ~ack_r;
	assign o_avs_readdata    = rdata_r;

	// pin inputs: 3..0 channels, 4 external event, 5 subclock
	wire [5:0] pins   = {i_subclk, i_ext_event_pin, i_ch_pin};
	wire [5:0] agree  = ~(sy2_r ^ sy3_r);
	assign stb_nxt    = (agree & sy3_r) | (~agree & stb_r);
	wire [5:0] rise_e = stb_nxt & ~stb_r;
	wire [5:0] fall_e = ~stb_nxt & stb_r;

	// count source
	wire [2:0] cks     = ctrl_r[`TW_CTRL_CKS_HI:`TW_CTRL_CKS_LO];
	wire       tick_d2 = pre_r[0];
	wire       tick_d4 = &pre_r[1:0];
	wire       tick_d8 = &pre_r[2:0];
	wire       tick_d1 = i_sub_mode ? rise_e[5] : 1'b1; // RULE_08
	wire       tick    = cks[2] ? rise_e[4] : // RULE_07
	                     (cks[1:0] == 2'b00) ? tick_d1 :
	                     (cks[1:0] == 2'b01) ? tick_d2 :
	                     (cks[1:0] == 2'b10) ? tick_d4 : tick_d8;
	wire       cnt_en  = mode_r[`TW_MODE_RUN] & tick; // RULE_01

	// channel configuration
	wire       buf_a = mode_r[`TW_MODE_BUFA];
	wire       buf_b = mode_r[`TW_MODE_BUFB];
	wire [3:0] pwm   = {mode_r[`TW_MODE_PWM_SEL_D], mode_r[`TW_MODE_PWM_SEL_C],
	                    mode_r[`TW_MODE_PWM_SEL_B], 1'b0}; // RULE_04
	wire [3:0] fsel  = {iocd_r[`TW_IO_HI_FS], iocd_r[`TW_IO_LO_FS],
	                    ioab_r[`TW_IO_HI_FS], ioab_r[`TW_IO_LO_FS]}; // RULE_17 RULE_20 RULE_24
	wire [1:0] fld [4];
	assign fld[0] = ioab_r[1:0];
	assign fld[1] = ioab_r[5:4];
	assign fld[2] = iocd_r[1:0];
	assign fld[3] = iocd_r[5:4];
	// a register serving as buffer has no compare or capture of its own
	wire [3:0] own = {~buf_b, ~buf_a, 2'b11}; // RULE_02 RULE_03
	// pwm forces compare operation
	wire [3:0] oc  = ~fsel | pwm;
	wire [3:0] cap = fsel & ~pwm;
	wire [3:0] match;
	wire [3:0] capt;
	for (genvar i = 0; i < 4; i++) begin : g_ch
		wire hit    = cnt_r == gr_r[i];
		wire edge_s = fld[i][1] ? (rise_e[i] | fall_e[i]) : // RULE_19
		              fld[i][0] ? fall_e[i] : rise_e[i];
		assign match[i] = own[i] & oc[i] & cnt_en & hit; // RULE_15
		assign capt[i]  = own[i] & cap[i] & edge_s; // RULE_16
	end
	wire [3:0] evt   = match | capt;
	wire       clr_a = ctrl_r[`TW_CTRL_CLR] & match[0]; // RULE_06
	wire       wrap  = cnt_en & ~clr_a & (cnt_r == `TW_CNT_MAX) & ~wr_cnt; // RULE_13

	// counter: a bus write beats a count in the same cycle
	always_comb begin
		cnt_nxt = cnt_r;
		if (wr_cnt) begin
			cnt_nxt = wd16;
		end else if (clr_a) begin
			cnt_nxt = `TW_RST_CNT; // RULE_06
		end else if (cnt_en) begin
			cnt_nxt = cnt_r + 16'h0001;
		end
	end

	// general registers and the buffer transfers
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			gr_nxt[i] = gr_r[i];
		end
		for (int i = 0; i < 4; i++) begin
			if (capt[i]) begin
				gr_nxt[i] = cnt_r; // RULE_16
			end
		end
		if (buf_a && capt[0]) begin
			gr_nxt[2] = gr_r[0]; // RULE_21
		end
		if (buf_a && match[0]) begin
			gr_nxt[0] = gr_r[2]; // RULE_21
		end
		if (buf_b && capt[1]) begin
			gr_nxt[3] = gr_r[1]; // RULE_02
		end
		if (buf_b && match[1]) begin
			gr_nxt[1] = gr_r[3]; // RULE_02
		end
		for (int i = 0; i < 4; i++) begin
			if (wr_gr[i]) begin
				gr_nxt[i] = wd16;
			end
		end
	end

	// pin levels
	always_comb begin
		lvl_nxt = lvl_r;
		for (int i = 0; i < 4; i++) begin
			if (wr_ctrl) begin
				lvl_nxt[i] = wd8[i]; // RULE_10
			end else if (pwm[i]) begin
				// equal period and duty leave the pin unchanged
				if (match[0] && !match[i]) begin
					lvl_nxt[i] = ctrl_r[i]; // RULE_22
				end else if (match[i] && !match[0]) begin
					lvl_nxt[i] = ~ctrl_r[i]; // RULE_22
				end
			end else if (match[i]) begin
				case (tw_pkg::tw_action_t'(fld[i])) // RULE_18
					tw_pkg::TW_ACT_LOW:    lvl_nxt[i] = 1'b0;
					tw_pkg::TW_ACT_HIGH:   lvl_nxt[i] = 1'b1;
					tw_pkg::TW_ACT_TOGGLE: lvl_nxt[i] = ~lvl_r[i];
					default:               lvl_nxt[i] = lvl_r[i];
				endcase
			end
		end
	end
	assign o_ch_out  = lvl_r; // RULE_09
	assign o_ch_oe_n = ~(oc & own);

	// status flags: 4 overflow, 3..0 channels d..a
	wire [4:0] stat_wd = {wd8[`TW_STAT_OVF], wd8[3:0]};
	wire [4:0] clr_req = {5{wr_stat}} & armed_r & ~stat_wd; // RULE_14
	wire [4:0] set_req = {wrap, evt};
	assign flag_nxt = (flag_r & ~clr_req) | set_req; // RULE_25
	wire [4:0] seen = {rdata_r[`TW_STAT_OVF], rdata_r[3:0]};

	assign o_overflow_interrupt = flag_r[4] & ien_r[`TW_IEN_OVF]; // RULE_11
	assign o_event_interrupt    = flag_r[3:0] & ien_r[3:0]; // RULE_12

	// read mux
	wire [7:0] stat_rd = {flag_r[4], 3'b000, flag_r[3:0]} | `TW_STAT_RSVD; // RULE_05
	wire [15:0] gr_rd  = sel_gr[0] ? gr_r[0] : sel_gr[1] ? gr_r[1] :
	                     sel_gr[2] ? gr_r[2] : gr_r[3];
	wire [31:0] rd_mux =
		sel_mode ? {24'h000000, mode_r | `TW_MODE_RSVD} : // RULE_05
		sel_ctrl ? {24'h000000, ctrl_r} :
		sel_ien  ? {24'h000000, ien_r | `TW_IEN_RSVD} :
		sel_stat ? {24'h000000, stat_rd} :
		sel_ioab ? {24'h000000, ioab_r | `TW_IO_RSVD} : // RULE_05
		sel_iocd ? {24'h000000, iocd_r | `TW_IO_RSVD} :
		sel_cnt  ? {16'h0000, cnt_r} :
		(|sel_gr) ? {16'h0000, gr_rd} : 32'h00000000;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h00000000;
		end else begin
			ack_r <= acc & ~ack_r;
			if (i_avs_read && !ack_r) begin
				rdata_r <= rd_mux;
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			sy1_r <= 6'h00;
			sy2_r <= 6'h00;
			sy3_r <= 6'h00;
			stb_r <= 6'h00;
			pre_r <= '0;
		end else begin
			sy1_r <= pins;
			sy2_r <= sy1_r;
			sy3_r <= sy2_r;
			stb_r <= stb_nxt;
			pre_r <= pre_r + 1'b1;
		end
	end

	// stored config keeps writable bits only; reserved bits are or-ed in on read
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			mode_r <= `TW_RST_BYTE; // RULE_01
			ctrl_r <= `TW_RST_BYTE;
			ien_r  <= `TW_RST_BYTE;
			ioab_r <= `TW_RST_BYTE;
			iocd_r <= `TW_RST_BYTE;
		end else begin
			if (wr_mode) begin
				mode_r <= wd8 & ~`TW_MODE_RSVD;
			end
			if (wr_ctrl) begin
				ctrl_r <= wd8;
			end
			if (wr_ien) begin
				ien_r <= wd8 & ~`TW_IEN_RSVD;
			end
			if (wr_ioab) begin
				ioab_r <= wd8 & ~`TW_IO_RSVD;
			end
			if (wr_iocd) begin
				iocd_r <= wd8 & ~`TW_IO_RSVD;
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			flag_r  <= 5'h00;
			armed_r <= 5'h00;
			lvl_r   <= 4'h0;
			cnt_r   <= `TW_RST_CNT; // RULE_23
		end else begin
			flag_r <= flag_nxt;
			lvl_r  <= lvl_nxt;
			cnt_r  <= cnt_nxt;
			if (wr_stat) begin
				armed_r <= 5'h00;
			end else if (rd_done && sel_stat) begin
				armed_r <= armed_r | seen; // RULE_14
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < 4; i++) begin
				gr_r[i] <= `TW_RST_GR; // RULE_23
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				gr_r[i] <= gr_nxt[i];
			end
		end
	end
endmodule : tw_timer
`default_nettype wire

// [tw_timer_checker.sv]
// concurrent checks on the timer ports
`timescale 1ns/100ps
`default_nettype none
`include "tw_map.svh"
module tw_timer_checker (
	input wire logic        i_clk_sys,
	input wire logic        i_rst,
	input wire logic [5:0]  i_avs_address,
	input wire logic        i_avs_read,
	input wire logic        i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic        o_avs_waitrequest,
	input wire logic [3:0]  o_ch_oe_n,
	input wire logic        o_overflow_interrupt,
	input wire logic [3:0]  o_event_interrupt
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	wire req = i_avs_read | i_avs_write;
	wire rda = i_avs_read & ~o_avs_waitrequest;
	wire wra = i_avs_write & ~o_avs_waitrequest;
	sequence s_asked; req && o_avs_waitrequest; endsequence
	sequence s_taken; req && !o_avs_waitrequest; endsequence
	a_one_wait: assert property (s_asked |=> s_taken) else $error("bus answer late");
	a_idle_free: assert property (!req |-> !o_avs_waitrequest) else $error("wait while idle");
	a_rd_upper: assert property (rda |-> o_avs_readdata[31:16] == 16'h0000)
		else $error("read upper half not zero");
	a_mode_rsvd: assert property (rda && i_avs_address == `TW_OFS_MODE |->
		(o_avs_readdata[7:0] & `TW_MODE_RSVD) == `TW_MODE_RSVD) else $error("mode spare bits");
	a_stat_rsvd: assert property (rda && i_avs_address == `TW_OFS_STAT |->
		o_avs_readdata[6:4] == 3'h7) else $error("status spare bits");
	a_io_rsvd: assert property (rda && i_avs_address[5:3] == 3'h2 |->
		(o_avs_readdata[7:0] & `TW_IO_RSVD) == `TW_IO_RSVD) else $error("io spare bits");
	a_ovf_hold: assert property ($fell(o_overflow_interrupt) |-> $past(wra))
		else $error("overflow request dropped without write");
	a_evt_hold: assert property (|($past(o_event_interrupt) & ~o_event_interrupt) |->
		$past(wra)) else $error("event request dropped without write");
	a_oe_write: assert property (!$stable(o_ch_oe_n) |-> $past(wra))
		else $error("pin direction moved without write");
endmodule : tw_timer_checker
`default_nettype wire

// [tw_pin_model.sv]
// pin-side stimulus model for the timer
`timescale 1ns/100ps
`default_nettype none
module tw_pin_model (
	input  wire logic       i_clk_sys,
	output logic      [3:0] o_ch_pin,
	output logic            o_ext_pin,
	output logic            o_subclk
);
	// subclock rests low outside its bursts, so no false rising edge after reset
	initial begin
		o_ch_pin = 4'h0;
		o_ext_pin = 1'b0;
		o_subclk = 1'b0;
	end
	// four clocks per level, above the three-clock input filter
	task automatic set_pin(input int c, input logic l);
		@(posedge i_clk_sys);
		o_ch_pin[c] <= l;
		repeat (4) @(posedge i_clk_sys);
	endtask : set_pin
	task automatic ext_flip;
		@(posedge i_clk_sys);
		o_ext_pin <= ~o_ext_pin;
		repeat (4) @(posedge i_clk_sys);
	endtask : ext_flip
	task automatic sub_flip;
		@(posedge i_clk_sys);
		o_subclk <= ~o_subclk;
		repeat (4) @(posedge i_clk_sys);
	endtask : sub_flip
endmodule : tw_pin_model
`default_nettype wire

// [test_timer_w_capture_compare_regs.sv]
// self-checking bench for the capture/compare timer
`timescale 1ns/100ps
`default_nettype none
`include "tw_map.svh"
module test_timer_w_capture_compare_regs;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [5:0]  adr = 6'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0]  be = 4'hf;
	logic        smode = 1'b0;
	logic [31:0] rdat;
	logic        wt;
	logic [3:0]  pin;
	logic [3:0]  cout;
	logic [3:0]  oe_n;
	logic [3:0]  eirq;
	logic        ext;
	logic        sub;
	logic        oirq;
	logic [31:0] v;
	int          fails = 0;
	int          total_checks = 0;
	always #2.5 clk = ~clk;
	tw_timer #(.PRE_W(3)) dut (.i_clk_sys(clk), .i_rst(rst), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wt), .i_ch_pin(pin), .o_ch_out(cout),
		.o_ch_oe_n(oe_n), .i_ext_event_pin(ext), .i_subclk(sub), .i_sub_mode(smode),
		.o_overflow_interrupt(oirq), .o_event_interrupt(eirq));
	tw_pin_model pins (.i_clk_sys(clk), .o_ch_pin(pin), .o_ext_pin(ext), .o_subclk(sub));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// holds the request until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= ~w;
		do @(posedge clk); while (wt !== 1'b0);
		v = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	task automatic rc(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(v, e);
	endtask : rc
	task automatic t_reset;
		rc(`TW_OFS_MODE, 32'h48);
		rc(`TW_OFS_STAT, 32'h70);
		rc(`TW_OFS_CNT, 32'h0);
		rc(`TW_OFS_GRD, 32'hffff);
		be <= 4'h1;
		bus(1'b1, `TW_OFS_GRD, 32'h5555);
		be <= 4'hf;
		rc(`TW_OFS_GRD, 32'hffff);
		bus(1'b1, `TW_OFS_IOCD, 32'h77);
		rc(`TW_OFS_IOCD, 32'hff);
		bus(1'b1, `TW_OFS_IOCD, 32'h0);
		$display("reset test done");
	endtask : t_reset
	task automatic t_rate;
		int n;
		for (int k = 0; k < 5; k++) begin
			bus(1'b1, `TW_OFS_CNT, 32'h0);
			bus(1'b1, `TW_OFS_CTRL, 32'(k) << 4);
			bus(1'b1, `TW_OFS_MODE, 32'h80);
			if (k == 4) repeat (10) pins.ext_flip;
			else repeat (64) @(posedge clk);
			bus(1'b1, `TW_OFS_MODE, 32'h0);
			bus(1'b0, `TW_OFS_CNT, 32'h0);
			n = (k == 4) ? 5 : 67 >> k;
			chk(v + 1 >= n && v <= n + 1, 1);
		end
		repeat (20) @(posedge clk);
		rc(`TW_OFS_CNT, v);
		$display("rate test done");
	endtask : t_rate
	// undivided source in sub mode must count subclock edges, not system clocks
	task automatic t_sub;
		bus(1'b1, `TW_OFS_CNT, 32'h0);
		bus(1'b1, `TW_OFS_CTRL, 32'h0);
		smode <= 1'b1;
		bus(1'b1, `TW_OFS_MODE, 32'h80);
		repeat (10) pins.sub_flip;
		bus(1'b1, `TW_OFS_MODE, 32'h0);
		smode <= 1'b0;
		rc(`TW_OFS_CNT, 32'h5);
		$display("subclock test done");
	endtask : t_sub
	task automatic t_ovf;
		bus(1'b1, `TW_OFS_CTRL, 32'h0);
		bus(1'b1, `TW_OFS_CNT, 32'hfffe);
		bus(1'b1, `TW_OFS_MODE, 32'h80);
		repeat (8) @(posedge clk);
		bus(1'b1, `TW_OFS_MODE, 32'h0);
		chk(oirq, 0);
		rc(`TW_OFS_STAT, 32'hff);
		bus(1'b1, `TW_OFS_IEN, 32'h80);
		bus(1'b1, `TW_OFS_STAT, 32'hff);
		bus(1'b1, `TW_OFS_STAT, 32'h0);
		@(negedge clk);
		chk(oirq, 1);
		rc(`TW_OFS_STAT, 32'hff);
		bus(1'b1, `TW_OFS_STAT, 32'h0);
		@(negedge clk);
		chk(oirq, 0);
		$display("overflow test done");
	endtask : t_ovf
	task automatic t_cmp;
		bus(1'b1, `TW_OFS_GRA, 32'h9);
		bus(1'b1, `TW_OFS_IEN, 32'h1);
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, `TW_OFS_CNT, 32'h0);
			bus(1'b1, `TW_OFS_CTRL, 32'h81);
			@(negedge clk);
			chk(cout[0], 1);
			bus(1'b1, `TW_OFS_IOAB, 32'(k));
			bus(1'b1, `TW_OFS_MODE, 32'h80);
			for (int i = 0; i < 99 && eirq[0] !== 1'b1; i++) @(negedge clk);
			chk(cout[0], (4'h5 >> k) & 1);
			chk(eirq[0], 1);
			bus(1'b0, `TW_OFS_CNT, 32'h0);
			chk(v < 32'ha, 1);
			bus(1'b1, `TW_OFS_MODE, 32'h0);
			bus(1'b0, `TW_OFS_STAT, 32'h0);
			bus(1'b1, `TW_OFS_STAT, 32'h0);
			@(negedge clk);
			chk(eirq[0], 0);
		end
		$display("compare test done");
	endtask : t_cmp
	task automatic t_cap;
		bus(1'b1, `TW_OFS_CNT, 32'h1234);
		bus(1'b1, `TW_OFS_IOAB, 32'h40);
		bus(1'b1, `TW_OFS_IOCD, 32'h65);
		@(negedge clk);
		chk(oe_n, 4'he);
		for (int c = 1; c < 4; c++) pins.set_pin(c, 1'b1);
		rc(`TW_OFS_GRC, 32'hffff);
		rc(`TW_OFS_GRD, 32'h1234);
		bus(1'b1, `TW_OFS_CNT, 32'h2222);
		for (int c = 1; c < 4; c++) pins.set_pin(c, 1'b0);
		rc(`TW_OFS_GRB, 32'h1234);
		rc(`TW_OFS_GRC, 32'h2222);
		rc(`TW_OFS_GRD, 32'h2222);
		rc(`TW_OFS_STAT, 32'h7e);
		bus(1'b1, `TW_OFS_MODE, 32'h10);
		bus(1'b1, `TW_OFS_IOAB, 32'h44);
		pins.set_pin(0, 1'b1);
		rc(`TW_OFS_GRA, 32'h2222);
		rc(`TW_OFS_GRC, 32'h9);
		$display("capture test done");
	endtask : t_cap
	// pwm on b overrides its capture select; d buffers b
	task automatic t_pwm;
		bus(1'b1, `TW_OFS_IOAB, 32'h40);
		bus(1'b1, `TW_OFS_GRA, 32'h9);
		bus(1'b1, `TW_OFS_GRB, 32'h4);
		bus(1'b1, `TW_OFS_GRD, 32'h6);
		bus(1'b1, `TW_OFS_CNT, 32'h0);
		bus(1'b1, `TW_OFS_CTRL, 32'h82);
		bus(1'b1, `TW_OFS_MODE, 32'ha1);
		@(negedge clk);
		chk(oe_n[1], 0);
		for (int i = 0; i < 99 && cout[1] !== 1'b0; i++) @(negedge clk);
		chk(cout[1], 0);
		for (int i = 0; i < 99 && cout[1] !== 1'b1; i++) @(negedge clk);
		chk(cout[1], 1);
		bus(1'b1, `TW_OFS_MODE, 32'h0);
		rc(`TW_OFS_GRB, 32'h6);
		$display("pwm test done");
	endtask : t_pwm
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : final_report
	// the whole sequence needs under a thousand clocks
	initial begin
		repeat (40000) @(posedge clk);
		fails++;
		final_report;
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_rate;
		t_sub;
		t_ovf;
		t_cmp;
		t_cap;
		t_pwm;
		final_report;
	end
endmodule : test_timer_w_capture_compare_regs
bind tw_timer tw_timer_checker u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
	.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
	.o_ch_oe_n(o_ch_oe_n), .o_overflow_interrupt(o_overflow_interrupt),
	.o_event_interrupt(o_event_interrupt));
`default_nettype wire
